// >>> hw/dio_port_params.svh
`ifndef DIO_PORT_PARAMS_SVH
`define DIO_PORT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry of the connectors and groups, timeout width, star slot and reset values
// ----------------------------------------------------------------------------
`define LINES_PER_GROUP        8
`define GROUPS_CONN0           2
`define GROUPS_CONN12          5
`define CONN_COUNT             3
`define TRIG_COUNT             8
`define TIMEOUT_WIDTH          32
`define SLOT_TWO               5'h02
`define RESET_OUT_VALUE        1'b0
`define RESET_OUT_ENABLE       1'b0

`endif

// >>> hw/dio_port_pkg.sv
package dio_port_pkg;

   // ----------------------------------------------------------------------------
   // Wait operations
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      WAIT_ANY_EDGE     = 3'h0,
      WAIT_FALLING_EDGE = 3'h1,
      WAIT_RISING_EDGE  = 3'h2,
      WAIT_HIGH_LEVEL   = 3'h3,
      WAIT_LOW_LEVEL    = 3'h4
   } wait_kind_type;

   typedef enum logic [1:0] {
      WAIT_IDLE  = 2'b00,
      WAIT_ARMED = 2'b01,
      WAIT_DONE  = 2'b10
   } wait_state_type;

   // Arbitration applied per channel when two requesters write in one cycle.
   typedef enum logic [1:0] {
      ARB_NONE       = 2'b00,
      ARB_PRIORITY_A = 2'b01,
      ARB_ROUND_ROBIN = 2'b10
   } arb_mode_type;

endpackage

// >>> hw/dio_port_edge_wait.sv
// Function
// - Lines grouped into eight-line ports.
// - Per channel value, enable and input.
// - Any-edge wait ends on either transition.
// - Falling wait ends on high-to-low.
// - Rising wait ends on low-to-high.
// - High wait completes when line high.
// - Low wait completes when line low.
// - Signed tick timeout; zero times out immediately.
// - Negative timeout waits forever.
// - Positive timeout counts ticks, then expires.
// - Port n holds lines 8n..8n+7, LSB lowest.
// - Reference clock input is read only.
// - Per-channel arbitration setting for concurrent access.
// - Line and port accesses take one cycle.
`include "dio_port_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dio_port_edge_wait
   import dio_port_pkg::*;
#(
   parameter int GROUPS      = `GROUPS_CONN0 + 2 * `GROUPS_CONN12,
   parameter int LINES       = GROUPS * `LINES_PER_GROUP,
   parameter int CHANS       = LINES + `TRIG_COUNT + 1,
   parameter int IDX_W       = $clog2(CHANS),
   parameter int GRP_W       = $clog2(GROUPS)
) (
   // Clock and reset
   input  wire logic                      core_clk_in,
   input  wire logic                      rst_n_in,
   // Pins: digital lines (low LINES), triggers (next TRIG_COUNT), star (top bit)
   input  wire logic [CHANS-1:0]          pin_in,
   output logic      [CHANS-1:0]          pin_out,
   output logic      [CHANS-1:0]          pin_oe_out,
   input  wire logic                      ref_clk10_in,
   input  wire logic [4:0]                slot_in,
   // Per-channel arbitration setting
   input  wire logic [2*CHANS-1:0]        arb_mode_in,
   // Requester A: single line access
   input  wire logic                      a_line_wr_in,
   input  wire logic                      a_line_en_wr_in,
   input  wire logic [IDX_W-1:0]          a_line_idx_in,
   input  wire logic                      a_line_val_in,
   output logic                           a_line_rd_out,
   // Requester B: eight-line group access
   input  wire logic                      b_grp_wr_in,
   input  wire logic                      b_grp_en_wr_in,
   input  wire logic [GRP_W-1:0]          b_grp_idx_in,
   input  wire logic [`LINES_PER_GROUP-1:0] b_grp_val_in,
   output logic      [`LINES_PER_GROUP-1:0] b_grp_rd_out,
   // Reference clock and slot readback
   output logic                           ref_clk10_out,
   output logic                           star_blocked_out,
   // Wait operation
   input  wire logic                      wait_start_in,
   input  wire logic [2:0]                wait_kind_in,
   input  wire logic [IDX_W-1:0]          wait_idx_in,
   input  wire logic signed [`TIMEOUT_WIDTH-1:0] wait_timeout_in,
   output logic                           wait_busy_out,
   output logic                           wait_done_out,
   output logic                           wait_timed_out_out
);

   // ----------------------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------------------
   logic                 rst_s1_q;
   logic                 rst_q;
   logic [CHANS-1:0]     pin_s1_q;
   logic [CHANS-1:0]     pin_s2_q;
   logic [CHANS-1:0]     pin_prev_q;
   logic                 ref_s1_q;
   logic                 ref_s2_q;

   // Every register below leaves reset on the same edge, two clocks after the pin lets go,
   // so no request may be given before the third edge after release.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_q    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_q    <= rst_s1_q;
      end
   end

   // The previous sample feeds the edge waits and is taken only from the second flop.
   always_ff @(posedge core_clk_in or negedge rst_q) begin
      if (!rst_q) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         pin_prev_q <= '0;
         ref_s1_q   <= 1'b0;
         ref_s2_q   <= 1'b0;
      end else begin
         pin_s1_q   <= pin_in;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
         ref_s1_q   <= ref_clk10_in;
         ref_s2_q   <= ref_s1_q;
      end
   end

   // Only readable, never driven.
   assign ref_clk10_out = ref_s2_q;

   // ----------------------------------------------------------------------------
   // Output value and enable per channel
   // ----------------------------------------------------------------------------
   function automatic logic line_in_group(input logic [IDX_W-1:0] ch,
                                          input logic [GRP_W-1:0] grp);
      line_in_group = (int'(ch) / `LINES_PER_GROUP) == int'(grp) && int'(ch) < LINES;
   endfunction

   logic                 star_blocked;
   logic [CHANS-1:0]     out_q;
   logic [CHANS-1:0]     out_d;
   logic [CHANS-1:0]     oe_q;
   logic [CHANS-1:0]     oe_d;
   logic [CHANS-1:0]     rr_q;
   logic [CHANS-1:0]     rr_d;

   // Driving the star line in slot two would disturb the chassis reference.
   assign star_blocked     = (slot_in == `SLOT_TWO);
   assign star_blocked_out = star_blocked;

   generate
      for (genvar c = 0; c < CHANS; c++) begin : g_chan
         always_comb begin
            logic         a_hit;
            logic         b_hit;
            logic         a_wins;
            logic         b_bit;
            arb_mode_type mode;
            a_wins = 1'b0;
            a_hit  = (int'(a_line_idx_in) == c) && (a_line_wr_in || a_line_en_wr_in);
            b_hit  = (b_grp_wr_in || b_grp_en_wr_in) && line_in_group(IDX_W'(c), b_grp_idx_in);
            b_bit  = b_grp_val_in[c % `LINES_PER_GROUP];
            mode   = arb_mode_type'(arb_mode_in[2*c +: 2]);
            out_d[c] = out_q[c];
            oe_d[c]  = oe_q[c];
            rr_d[c]  = rr_q[c];
            // Collisions are resolved by the channel's own setting.
            // The alternation bit flips on every collision whatever the mode, so a switch to
            // alternating starts from wherever the last collision left it.
            case (mode)
               ARB_PRIORITY_A:  a_wins = 1'b1;
               ARB_ROUND_ROBIN: a_wins = !rr_q[c];
               default:         a_wins = 1'b0;
            endcase
            if (a_hit && (!b_hit || a_wins)) begin
               if (a_line_wr_in)
                  out_d[c] = a_line_val_in;
               if (a_line_en_wr_in)
                  oe_d[c] = a_line_val_in;
            end else if (b_hit) begin
               if (b_grp_wr_in)
                  out_d[c] = b_bit;
               if (b_grp_en_wr_in)
                  oe_d[c] = b_bit;
            end
            if (a_hit && b_hit)
               rr_d[c] = !rr_q[c];
         end
      end
   endgenerate

   always_ff @(posedge core_clk_in or negedge rst_q) begin
      if (!rst_q) begin
         out_q <= {CHANS{`RESET_OUT_VALUE}};
         oe_q  <= {CHANS{`RESET_OUT_ENABLE}};
         rr_q  <= '0;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
         rr_q  <= rr_d;
      end
   end

   always_comb begin
      pin_out    = out_q;
      pin_oe_out = oe_q;
      if (star_blocked) begin
         pin_out[CHANS-1]    = 1'b0;
         pin_oe_out[CHANS-1] = 1'b0;
      end
   end

   // Reads come straight from the synchronised pins in the same cycle.
   // A line index past the last channel reads as unknown; a group index past the last group reads trigger, star or unknown bits, so callers keep it in range.
   assign a_line_rd_out = pin_s2_q[a_line_idx_in];
   assign b_grp_rd_out  = pin_s2_q[b_grp_idx_in * `LINES_PER_GROUP +: `LINES_PER_GROUP];

   // ----------------------------------------------------------------------------
   // Wait engine
   // ----------------------------------------------------------------------------
   wait_state_type                 st_q;
   wait_state_type                 st_d;
   wait_kind_type                  kind_q;
   wait_kind_type                  kind_d;
   logic [IDX_W-1:0]               widx_q;
   logic [IDX_W-1:0]               widx_d;
   logic [`TIMEOUT_WIDTH-1:0]      left_q;
   logic [`TIMEOUT_WIDTH-1:0]      left_d;
   logic                           forever_q;
   logic                           forever_d;
   logic                           tout_q;
   logic                           tout_d;
   logic                           cur;
   logic                           prv;
   logic                           hit;

   // Edges are judged on the synchronised copy, so a pin change is seen two cycles late.
   assign cur = pin_s2_q[widx_q];
   assign prv = pin_prev_q[widx_q];

   always_comb begin
      case (kind_q)
         WAIT_ANY_EDGE:     hit = cur != prv;
         WAIT_FALLING_EDGE: hit = prv && !cur;
         WAIT_RISING_EDGE:  hit = !prv && cur;
         WAIT_HIGH_LEVEL:   hit = cur;
         WAIT_LOW_LEVEL:    hit = !cur;
         default:           hit = 1'b0;
      endcase
   end

   always_comb begin
      st_d      = st_q;
      kind_d    = kind_q;
      widx_d    = widx_q;
      left_d    = left_q;
      forever_d = forever_q;
      tout_d    = tout_q;
      case (st_q)
         WAIT_IDLE, WAIT_DONE: begin
            st_d = WAIT_IDLE;
            if (wait_start_in) begin
               kind_d    = wait_kind_type'(wait_kind_in);
               widx_d    = wait_idx_in;
               left_d    = wait_timeout_in;
               // A negative timeout keeps the wait armed until its condition shows.
               forever_d = wait_timeout_in < 0;
               tout_d    = 1'b0;
               // A zero timeout never arms; the requester sees done one cycle after its start.
               if (wait_timeout_in == 0) begin
                  st_d   = WAIT_DONE;
                  tout_d = 1'b1;
               end else begin
                  st_d = WAIT_ARMED;
               end
            end
         end
         WAIT_ARMED: begin
            // Condition seen in the last tick beats an expiring count.
            if (hit) begin
               st_d   = WAIT_DONE;
               tout_d = 1'b0;
            end else if (!forever_q) begin
               left_d = left_q - `TIMEOUT_WIDTH'(1);
               if (left_q == `TIMEOUT_WIDTH'(1)) begin
                  st_d   = WAIT_DONE;
                  tout_d = 1'b1;
               end
            end
         end
         default: st_d = WAIT_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_q) begin
      if (!rst_q) begin
         st_q      <= WAIT_IDLE;
         kind_q    <= WAIT_ANY_EDGE;
         widx_q    <= '0;
         left_q    <= '0;
         forever_q <= 1'b0;
         tout_q    <= 1'b0;
      end else begin
         st_q      <= st_d;
         kind_q    <= kind_d;
         widx_q    <= widx_d;
         left_q    <= left_d;
         forever_q <= forever_d;
         tout_q    <= tout_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Wait status
   // ----------------------------------------------------------------------------
   // Done stands for one cycle; the timed-out flag stands until the next start.
   assign wait_busy_out      = (st_q == WAIT_ARMED);
   assign wait_done_out      = (st_q == WAIT_DONE);
   assign wait_timed_out_out = tout_q;

endmodule

`default_nettype wire

// >>> testbench/dio_port_edge_wait_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Port checker
// ---------------
module dio_port_edge_wait_monitor #(
   parameter int CHANS = 105,
   parameter int IDX_W = 7,
   parameter int GRP_W = 4
) (
   input wire logic                    core_clk_in,
   input wire logic                    rst_n_in,
   input wire logic [CHANS-1:0]        pin_out,
   input wire logic [CHANS-1:0]        pin_oe_out,
   input wire logic                    ref_clk10_in,
   input wire logic                    ref_clk10_out,
   input wire logic [4:0]              slot_in,
   input wire logic                    star_blocked_out,
   input wire logic                    a_line_wr_in,
   input wire logic [IDX_W-1:0]        a_line_idx_in,
   input wire logic                    a_line_val_in,
   input wire logic                    a_line_rd_out,
   input wire logic                    b_grp_wr_in,
   input wire logic [GRP_W-1:0]        b_grp_idx_in,
   input wire logic [7:0]              b_grp_val_in,
   input wire logic [7:0]              b_grp_rd_out,
   input wire logic                    wait_start_in,
   input wire logic signed [31:0]      wait_timeout_in,
   input wire logic                    wait_busy_out,
   input wire logic                    wait_done_out,
   input wire logic                    wait_timed_out_out
);
   logic signed [31:0] tmo_q;
   logic signed [31:0] cnt_q;
   logic [2:0]         up_q;
   wire logic          acc = wait_start_in && !wait_busy_out;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmo_q <= '0;
         cnt_q <= '0;
         up_q <= '0;
      end else begin
         cnt_q <= acc ? 32'sh0 : cnt_q + 32'sh1;
         tmo_q <= acc ? wait_timeout_in : tmo_q;
         up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   line_write_a: assert property (a_line_wr_in && !b_grp_wr_in && a_line_idx_in < CHANS-1
      |=> pin_out[$past(a_line_idx_in)] == $past(a_line_val_in)) else $error("line write lost");
   group_write_a: assert property (b_grp_wr_in && !a_line_wr_in && b_grp_idx_in < 12
      |=> pin_out[8*$past(b_grp_idx_in) +: 8] == $past(b_grp_val_in)) else $error("group write lost");
   read_pair_a: assert property (a_line_idx_in[IDX_W-1:3] == b_grp_idx_in && a_line_idx_in < 96
      |-> a_line_rd_out == b_grp_rd_out[a_line_idx_in[2:0]]) else $error("line and group reads differ");
   ref_sync_a: assert property (up_q == 3'h7 |-> ref_clk10_out == $past(ref_clk10_in, 2))
      else $error("reference copy wrong");
   star_block_a: assert property (star_blocked_out |-> !pin_out[CHANS-1] && !pin_oe_out[CHANS-1])
      else $error("star driven in slot two");
   slot_decode_a: assert property (star_blocked_out == (slot_in == 5'h02))
      else $error("slot decode wrong");
   zero_tmo_a: assert property (acc && wait_timeout_in == 0 |=> wait_done_out && wait_timed_out_out)
      else $error("zero timeout not immediate");
   tick_count_a: assert property (wait_done_out && wait_timed_out_out |-> cnt_q == tmo_q)
      else $error("timeout tick count wrong");
   never_expire_a: assert property (wait_done_out && tmo_q < 0 |-> !wait_timed_out_out)
      else $error("negative timeout expired");
   done_cause_a: assert property (wait_done_out
      |-> !wait_busy_out && ($past(wait_busy_out) || $past(wait_start_in))) else $error("done without a wait");
   cover property (acc && wait_timeout_in < 0);
   cover property (wait_done_out && wait_timed_out_out);
   cover property ($rose(star_blocked_out));
endmodule
bind dio_port_edge_wait dio_port_edge_wait_monitor #(.CHANS(CHANS), .IDX_W(IDX_W), .GRP_W(GRP_W))
   i_dio_port_edge_wait_monitor (.*);
`default_nettype wire

// >>> testbench/dio_lines_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Far side lines
// ---------------
module dio_lines_model #(
   parameter int CHANS = 105
) (
   input  wire logic [CHANS-1:0] pin_out,
   input  wire logic [CHANS-1:0] pin_oe_out,
   input  wire logic [CHANS-1:0] far_val_in,
   output logic      [CHANS-1:0] pin_in
);
   // A driven line shows the block's value; the far side only owns undriven lines.
   assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & far_val_in);
endmodule
`default_nettype wire

// >>> testbench/dio_port_edge_wait_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dio_port_edge_wait_tb;
   import dio_port_pkg::*;
   localparam int NCH = 105;
   logic clk = 0, rst_n = 0, ref_in = 0, a_wr = 0, a_en = 0, a_val = 0, b_wr = 0, b_en = 0, w_start = 0;
   logic [NCH-1:0] far = '0, pin_in, pin_out, pin_oe;
   logic [2*NCH-1:0] arb = '0;
   logic [6:0] a_idx = '0, w_idx = 7'h05;
   logic [3:0] b_idx = '0;
   logic [7:0] b_val = '0, b_rd;
   logic [4:0] slot = '0;
   logic [2:0] w_kind = '0;
   logic signed [31:0] w_tmo = '0;
   logic a_rd, ref_out, star_bl, busy, done, tmo_out;
   int fails = 0, checks = 0, cyc = 0, n;
   // ---------------
   // Block and far side
   // ---------------
   always #2 clk = ~clk;
   initial #1 forever #50 ref_in = ~ref_in;
   dio_port_edge_wait i_dio_port_edge_wait (.core_clk_in(clk), .rst_n_in(rst_n), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_out(pin_oe), .ref_clk10_in(ref_in), .slot_in(slot), .arb_mode_in(arb),
      .a_line_wr_in(a_wr), .a_line_en_wr_in(a_en), .a_line_idx_in(a_idx), .a_line_val_in(a_val),
      .a_line_rd_out(a_rd), .b_grp_wr_in(b_wr), .b_grp_en_wr_in(b_en), .b_grp_idx_in(b_idx),
      .b_grp_val_in(b_val), .b_grp_rd_out(b_rd), .ref_clk10_out(ref_out), .star_blocked_out(star_bl),
      .wait_start_in(w_start), .wait_kind_in(w_kind), .wait_idx_in(w_idx), .wait_timeout_in(w_tmo),
      .wait_busy_out(busy), .wait_done_out(done), .wait_timed_out_out(tmo_out));
   dio_lines_model i_dio_lines_model (.pin_out(pin_out), .pin_oe_out(pin_oe), .far_val_in(far), .pin_in(pin_in));
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic start_wait(input logic [2:0] kind, input logic signed [31:0] tmo);
      @(negedge clk);
      w_kind = kind;
      w_tmo = tmo;
      w_start = 1;
      @(negedge clk);
      w_start = 0;
   endtask
   task automatic wait_done();
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
   endtask
   // ---------------
   // Scenarios
   // ---------------
   task automatic t_lines();
      a_idx = 7'd9;
      a_val = 1;
      a_wr = 1;
      a_en = 1;
      @(negedge clk);
      a_wr = 0;
      a_en = 0;
      cmp(pin_out[9], 1, "line value");
      cmp(pin_oe[9], 1, "line enable");
      b_idx = 4'd11;
      b_val = 8'ha5;
      b_wr = 1;
      b_en = 1;
      @(negedge clk);
      b_wr = 0;
      b_en = 0;
      cmp(pin_out[95:88], 8'ha5, "group value");
      repeat (3) @(negedge clk);
      cmp(b_rd, 8'ha5, "group read");
      a_idx = 7'd90;
      #1 cmp(a_rd, 1, "line read");
      $display("lines test done");
   endtask
   task automatic t_arb();
      logic last;
      last = 1'b0;
      // Passes two and three both alternate, so their winners must differ.
      for (int m = 0; m < 4; m++) begin
         @(negedge clk);
         arb[33:32] = (m == 3) ? 2'h2 : m[1:0];
         a_idx = 7'd16;
         b_idx = 4'd2;
         b_val = 8'h00;
         a_wr = 1;
         b_wr = 1;
         @(negedge clk);
         a_wr = 0;
         b_wr = 0;
         if (m < 2)
            cmp(pin_out[16], m[0], "arbitration");
         else if (m == 3)
            cmp(pin_out[16], !last, "alternation");
         last = pin_out[16];
      end
      $display("arbitration test done");
   endtask
   task automatic t_star();
      // Only the slot three pass writes the star line, so slot two never sees an access.
      for (int s = 3; s > 1; s--) begin
         @(negedge clk);
         slot = s[4:0];
         a_idx = (s == 3) ? 7'd104 : 7'd0;
         a_wr = (s == 3);
         a_en = (s == 3);
         @(negedge clk);
         a_wr = 0;
         a_en = 0;
         cmp(pin_oe[104], s == 3, "star enable");
         cmp(star_bl, s == 2, "slot decode");
      end
      slot = '0;
      $display("star test done");
   endtask
   task automatic t_timeout();
      for (int t = 0; t < 6; t += 5) begin
         start_wait(WAIT_RISING_EDGE, t);
         wait_done();
         cmp(n[7:0], 8'(t), "ticks to timeout");
         cmp(tmo_out, 1, "timed out flag");
      end
      $display("timeout test done");
   endtask
   task automatic t_waits();
      logic [4:0] pre;
      pre = 5'b10010;
      for (int k = 0; k < 5; k++) begin
         far[5] = pre[k];
         repeat (4) @(negedge clk);
         start_wait(k[2:0], -32'sd1);
         repeat (6) @(negedge clk);
         cmp(busy, 1, "stall before change");
         far[5] = ~pre[k];
         wait_done();
         cmp(n <= 4, 1, "condition seen");
         cmp(tmo_out, 0, "condition flag");
      end
      $display("wait test done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      repeat (4) @(negedge clk);
      t_lines();
      t_arb();
      t_star();
      t_timeout();
      t_waits();
      report_and_stop();
   end
endmodule
`default_nettype wire
